// [shared/cabx_pkg.sv]
// constants and types for the execute block
// assumes one core clock, synchronous active-high reset
package cabx_pkg;
  // ****************
  // operations
  // ****************
  typedef enum logic [5:0] {
    op_none, op_add, op_add_carry, op_add_immediate_word, op_subtract,
    op_subtract_immediate, op_subtract_with_borrow, op_subtract_immediate_with_borrow,
    op_subtract_immediate_word, op_and, op_and_immediate, op_or, op_or_immediate,
    op_exclusive_or, op_clear_bits_by_mask, op_set_bits_by_mask, op_test_zero_minus,
    op_pointer_jump, op_pointer_subroutine, op_compare_skip_equal, op_compare_immediate,
    op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear, op_skip_io_bit_set,
    op_branch_status_bit_set, op_branch_status_bit_clear, op_branch_signed_ge,
    op_branch_signed_lt, op_branch_half_carry_set, op_branch_half_carry_clear,
    op_branch_irq_enabled, op_branch_irq_disabled, op_set_io_bit, op_clear_io_bit,
    op_rotate_left_carry
  } cabx_op_t;

  typedef enum logic [2:0] {fn_add, fn_sub, fn_and, fn_or, fn_xor, fn_rol} cabx_fn_t;

  // ****************
  // status bit positions
  // ****************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ****************
  // limits and cycle counts
  // ****************
  localparam logic [5:0] IO_BIT_ADDR_MAX = 6'h1f;
  localparam logic [7:0] MASK_ALL        = 8'hff;
  localparam logic [1:0] CYC_ONE         = 2'h1;
  localparam logic [1:0] CYC_WORD        = 2'h2;
  localparam logic [1:0] CYC_JUMP        = 2'h2;
  localparam logic [1:0] CYC_CALL        = 2'h3;
  localparam logic [1:0] CYC_SKIP_ONE    = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO    = 2'h3;
  localparam logic [1:0] CYC_BR_TAKEN    = 2'h2;
  localparam logic [1:0] CYC_IO_BIT      = 2'h2;
endpackage

// [hdl/cabx_alu.sv]
// byte arithmetic and logic unit, purely combinational
// assumes operands and carry-in are stable for the cycle
`timescale 1ns/1ps
module cabx_alu (
  // operation
  input  cabx_pkg::cabx_fn_t fn_in,
  input  logic [7:0]         a_in,
  input  logic [7:0]         b_in,
  input  logic               cin_in,
  // result and flags
  output logic [7:0]         res_out,
  output logic               c_out,
  output logic               z_out,
  output logic               n_out,
  output logic               v_out,
  output logic               h_out
);
  logic [8:0] sum9;
  logic [8:0] dif9;

  assign sum9 = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin_in};
  assign dif9 = {1'b0, a_in} - {1'b0, b_in} - {8'h00, cin_in};

  always_comb begin
    res_out = sum9[7:0];
    c_out   = sum9[8];
    v_out   = 1'b0;
    h_out   = 1'b0;
    case (fn_in)
      cabx_pkg::fn_add: begin
        v_out = (a_in[7] & b_in[7] & ~res_out[7]) | (~a_in[7] & ~b_in[7] & res_out[7]);
        h_out = (a_in[3] & b_in[3]) | (b_in[3] & ~res_out[3]) | (~res_out[3] & a_in[3]);
      end
      cabx_pkg::fn_sub: begin
        res_out = dif9[7:0];
        c_out   = dif9[8];
        v_out   = (a_in[7] & ~b_in[7] & ~res_out[7]) | (~a_in[7] & b_in[7] & res_out[7]);
        h_out   = (~a_in[3] & b_in[3]) | (b_in[3] & res_out[3]) | (res_out[3] & ~a_in[3]);
      end
      cabx_pkg::fn_and: res_out = a_in & b_in;
      cabx_pkg::fn_or:  res_out = a_in | b_in;
      cabx_pkg::fn_xor: res_out = a_in ^ b_in;
      cabx_pkg::fn_rol: begin
        res_out = {a_in[6:0], cin_in};
        c_out   = a_in[7];
        v_out   = a_in[6] ^ a_in[7];
      end
      default: res_out = sum9[7:0];
    endcase
  end

  assign n_out = res_out[7];
  assign z_out = (res_out == 8'h00);
endmodule

// [hdl/cabx_execute.sv]
// execute stage: alu, word ops, jumps, skips, branches, io bits
// assumes operands are presented with start_in while busy_out is low
`timescale 1ns/1ps
module cabx_execute #(
  parameter int PC_W = 16
) (
  // clock and reset
  input  logic                 core_clk_in,
  input  logic                 sys_rst_in,
  // instruction issue
  input  logic                 start_in,
  input  cabx_pkg::cabx_op_t   op_in,
  input  logic [7:0]           rd_val_in,
  input  logic [7:0]           rdh_val_in,
  input  logic [7:0]           rr_val_in,
  input  logic [7:0]           imm_in,
  input  logic [2:0]           bit_sel_in,
  input  logic [6:0]           offset_in,
  input  logic [PC_W-1:0]      pc_in,
  input  logic [15:0]          z_ptr_in,
  input  logic                 next_two_word_in,
  // io space
  input  logic [5:0]           io_addr_in,
  input  logic [7:0]           io_rdata_in,
  // status load from elsewhere in the core
  input  logic                 status_load_in,
  input  logic [7:0]           status_wdata_in,
  // completion
  output logic                 busy_out,
  output logic                 done_out,
  output logic [7:0]           status_flags_out,
  // register file write
  output logic                 wr_en_out,
  output logic                 wr_word_out,
  output logic [7:0]           result_out,
  output logic [7:0]           result_hi_out,
  // program counter and stack
  output logic                 pc_load_out,
  output logic [PC_W-1:0]      pc_out,
  output logic                 push_out,
  output logic [PC_W-1:0]      ret_addr_out,
  // io write
  output logic                 io_we_out,
  output logic [5:0]           io_addr_out,
  output logic [7:0]           io_wdata_out
);
  // ****************
  // signals
  // ****************
  cabx_pkg::cabx_fn_t fn;
  logic [7:0]      opb;
  logic            cin;
  logic [7:0]      alu_res;
  logic            alu_c, alu_z, alu_n, alu_v, alu_h;
  logic [15:0]     word_in, word_sum, word_dif, word_res;
  logic            w_c, w_v;
  logic [PC_W-1:0] pc_seq, pc_rel, pc_skip1, pc_skip2;
  logic            take;
  logic            cond, is_skip, is_branch;
  logic            upd_znv, upd_c, upd_h, upd_s, word_src;
  logic            src_z, src_n, src_v, src_c;
  logic [7:0]      flags_next;
  logic [7:0]      res_lo, res_hi, io_wdata;
  logic            wr, wr_word, io_we, push;
  logic [PC_W-1:0] npc;
  logic [1:0]      cyc;
  logic [7:0]      status_flags_reg;
  logic [1:0]      cnt_reg;
  logic            pend_wr_reg, pend_word_reg, pend_io_reg, pend_push_reg;

  assign take = start_in & ~busy_out;

  cabx_alu u_alu (
    .fn_in   (fn),
    .a_in    (rd_val_in),
    .b_in    (opb),
    .cin_in  (cin),
    .res_out (alu_res),
    .c_out   (alu_c),
    .z_out   (alu_z),
    .n_out   (alu_n),
    .v_out   (alu_v),
    .h_out   (alu_h)
  );

  // ****************
  // word and pc arithmetic
  // ****************
  assign word_in  = {rdh_val_in, rd_val_in};
  assign word_sum = word_in + {10'h000, imm_in[5:0]};
  assign word_dif = word_in - {10'h000, imm_in[5:0]};
  assign pc_seq   = pc_in + PC_W'(1);
  assign pc_skip1 = pc_in + PC_W'(2);
  assign pc_skip2 = pc_in + PC_W'(3);
  assign pc_rel   = pc_in + PC_W'($signed(offset_in)) + PC_W'(1);

  // ****************
  // decode and execute
  // ****************
  always_comb begin
    fn        = cabx_pkg::fn_add;
    opb       = rr_val_in;
    cin       = 1'b0;
    upd_znv   = 1'b0;
    upd_c     = 1'b0;
    upd_h     = 1'b0;
    upd_s     = 1'b0;
    word_src  = 1'b0;
    wr        = 1'b0;
    wr_word   = 1'b0;
    io_we     = 1'b0;
    push      = 1'b0;
    cond      = 1'b0;
    is_skip   = 1'b0;
    is_branch = 1'b0;
    npc       = pc_seq;
    cyc       = cabx_pkg::CYC_ONE;
    io_wdata  = io_rdata_in;
    case (op_in)
      cabx_pkg::op_add, cabx_pkg::op_add_carry: begin
        cin = (op_in == cabx_pkg::op_add_carry) & status_flags_reg[cabx_pkg::FLAG_C];
        {wr, upd_znv, upd_c, upd_h} = 4'hf;
      end
      cabx_pkg::op_add_immediate_word: begin
        {wr_word, upd_znv, upd_c, upd_s, word_src} = 5'h1f;
        cyc = cabx_pkg::CYC_WORD;
      end
      cabx_pkg::op_subtract_immediate_word: begin
        {wr_word, upd_znv, upd_c, upd_s, word_src} = 5'h1f;
        cyc = cabx_pkg::CYC_WORD;
      end
      cabx_pkg::op_subtract, cabx_pkg::op_subtract_immediate: begin
        fn  = cabx_pkg::fn_sub;
        opb = (op_in == cabx_pkg::op_subtract) ? rr_val_in : imm_in;
        {wr, upd_znv, upd_c, upd_h} = 4'hf;
      end
      cabx_pkg::op_subtract_with_borrow, cabx_pkg::op_subtract_immediate_with_borrow: begin
        fn  = cabx_pkg::fn_sub;
        opb = (op_in == cabx_pkg::op_subtract_with_borrow) ? rr_val_in : imm_in;
        cin = status_flags_reg[cabx_pkg::FLAG_C];
        {wr, upd_znv, upd_c, upd_h} = 4'hf;
      end
      cabx_pkg::op_and, cabx_pkg::op_and_immediate: begin
        fn  = cabx_pkg::fn_and;
        opb = (op_in == cabx_pkg::op_and) ? rr_val_in : imm_in;
        {wr, upd_znv} = 2'h3;
      end
      cabx_pkg::op_or, cabx_pkg::op_or_immediate, cabx_pkg::op_set_bits_by_mask: begin
        fn  = cabx_pkg::fn_or;
        opb = (op_in == cabx_pkg::op_or) ? rr_val_in : imm_in;
        {wr, upd_znv} = 2'h3;
      end
      cabx_pkg::op_exclusive_or: begin
        fn = cabx_pkg::fn_xor;
        {wr, upd_znv} = 2'h3;
      end
      cabx_pkg::op_clear_bits_by_mask: begin
        fn  = cabx_pkg::fn_and;
        opb = cabx_pkg::MASK_ALL - imm_in;
        {wr, upd_znv} = 2'h3;
      end
      cabx_pkg::op_test_zero_minus: begin
        fn      = cabx_pkg::fn_and;
        opb     = rd_val_in;
        upd_znv = 1'b1;
      end
      cabx_pkg::op_pointer_jump: begin
        npc = z_ptr_in[PC_W-1:0];
        cyc = cabx_pkg::CYC_JUMP;
      end
      cabx_pkg::op_pointer_subroutine: begin
        npc  = z_ptr_in[PC_W-1:0];
        push = 1'b1;
        cyc  = cabx_pkg::CYC_CALL;
      end
      cabx_pkg::op_compare_skip_equal: begin
        is_skip = 1'b1;
        cond    = (rd_val_in == rr_val_in);
      end
      cabx_pkg::op_compare_immediate: begin
        fn  = cabx_pkg::fn_sub;
        opb = imm_in;
        {upd_znv, upd_c, upd_h} = 3'h7;
      end
      cabx_pkg::op_skip_reg_bit_clear, cabx_pkg::op_skip_reg_bit_set: begin
        is_skip = 1'b1;
        cond    = rr_val_in[bit_sel_in] == (op_in == cabx_pkg::op_skip_reg_bit_set);
      end
      cabx_pkg::op_skip_io_bit_clear, cabx_pkg::op_skip_io_bit_set: begin
        is_skip = 1'b1;
        cond    = io_rdata_in[bit_sel_in] == (op_in == cabx_pkg::op_skip_io_bit_set);
      end
      cabx_pkg::op_branch_status_bit_set, cabx_pkg::op_branch_status_bit_clear: begin
        is_branch = 1'b1;
        cond = status_flags_reg[bit_sel_in] == (op_in == cabx_pkg::op_branch_status_bit_set);
      end
      cabx_pkg::op_branch_signed_ge: begin
        is_branch = 1'b1;
        cond = ~(status_flags_reg[cabx_pkg::FLAG_N] ^ status_flags_reg[cabx_pkg::FLAG_V]);
      end
      cabx_pkg::op_branch_signed_lt: begin
        is_branch = 1'b1;
        cond = status_flags_reg[cabx_pkg::FLAG_N] ^ status_flags_reg[cabx_pkg::FLAG_V];
      end
      cabx_pkg::op_branch_half_carry_set, cabx_pkg::op_branch_half_carry_clear: begin
        is_branch = 1'b1;
        cond = status_flags_reg[cabx_pkg::FLAG_H] == (op_in == cabx_pkg::op_branch_half_carry_set);
      end
      cabx_pkg::op_branch_irq_enabled, cabx_pkg::op_branch_irq_disabled: begin
        is_branch = 1'b1;
        cond = status_flags_reg[cabx_pkg::FLAG_I] == (op_in == cabx_pkg::op_branch_irq_enabled);
      end
      cabx_pkg::op_set_io_bit, cabx_pkg::op_clear_io_bit: begin
        io_we    = (io_addr_in <= cabx_pkg::IO_BIT_ADDR_MAX);
        io_wdata = (op_in == cabx_pkg::op_set_io_bit) ? (io_rdata_in | (8'h01 << bit_sel_in))
                                                      : (io_rdata_in & ~(8'h01 << bit_sel_in));
        cyc      = cabx_pkg::CYC_IO_BIT;
      end
      cabx_pkg::op_rotate_left_carry: begin
        fn  = cabx_pkg::fn_rol;
        cin = status_flags_reg[cabx_pkg::FLAG_C];
        {wr, upd_znv, upd_c} = 3'h7;
      end
      default: cyc = cabx_pkg::CYC_ONE;
    endcase
    if (is_skip && cond) begin
      npc = next_two_word_in ? pc_skip2 : pc_skip1;
      cyc = next_two_word_in ? cabx_pkg::CYC_SKIP_TWO : cabx_pkg::CYC_SKIP_ONE;
    end
    if (is_branch && cond) begin
      npc = pc_rel;
      cyc = cabx_pkg::CYC_BR_TAKEN;
    end
  end

  // ****************
  // flag sources
  // ****************
  assign word_res = (op_in == cabx_pkg::op_add_immediate_word) ? word_sum : word_dif;
  assign w_c = (op_in == cabx_pkg::op_add_immediate_word) ? (~word_res[15] & rdh_val_in[7])
                                                          : (word_res[15] & ~rdh_val_in[7]);
  assign w_v = (op_in == cabx_pkg::op_add_immediate_word) ? (~rdh_val_in[7] & word_res[15])
                                                          : (rdh_val_in[7] & ~word_res[15]);

  always_comb begin
    src_z  = word_src ? (word_res == 16'h0000) : alu_z;
    src_n  = word_src ? word_res[15] : alu_n;
    src_v  = word_src ? w_v : alu_v;
    src_c  = word_src ? w_c : alu_c;
    res_lo = word_src ? word_res[7:0] : alu_res;
    res_hi = word_src ? word_res[15:8] : rdh_val_in;
    flags_next = status_flags_reg;
    if (upd_znv) begin
      flags_next[cabx_pkg::FLAG_Z] = src_z;
      flags_next[cabx_pkg::FLAG_N] = src_n;
      flags_next[cabx_pkg::FLAG_V] = src_v;
    end
    if (upd_c) begin
      flags_next[cabx_pkg::FLAG_C] = src_c;
    end
    if (upd_h) begin
      flags_next[cabx_pkg::FLAG_H] = alu_h;
    end
    if (upd_s) begin
      flags_next[cabx_pkg::FLAG_S] = src_n ^ src_v;
    end
  end

  // ****************
  // status register
  // ****************
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      status_flags_reg <= cabx_pkg::STATUS_RESET;
    end else if (take) begin
      status_flags_reg <= flags_next;
    end else if (status_load_in) begin
      status_flags_reg <= status_wdata_in;
    end
  end
  assign status_flags_out = status_flags_reg;

  // ****************
  // cycle sequencing
  // ****************
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      cnt_reg  <= 2'h0;
    end else if (take) begin
      busy_out <= (cyc != cabx_pkg::CYC_ONE);
      done_out <= (cyc == cabx_pkg::CYC_ONE);
      cnt_reg  <= cyc - 2'h1;
    end else begin
      busy_out <= busy_out & (cnt_reg != 2'h1);
      done_out <= busy_out & (cnt_reg == 2'h1);
      cnt_reg  <= busy_out ? cnt_reg - 2'h1 : 2'h0;
    end
  end

  // ****************
  // strobes at completion
  // ****************
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      {pend_wr_reg, pend_word_reg, pend_io_reg, pend_push_reg} <= 4'h0;
      {wr_en_out, wr_word_out, io_we_out, push_out, pc_load_out} <= 5'h00;
    end else if (take) begin
      {pend_wr_reg, pend_word_reg, pend_io_reg, pend_push_reg} <= {wr, wr_word, io_we, push};
      {wr_en_out, wr_word_out, io_we_out, push_out} <= (cyc == cabx_pkg::CYC_ONE) ?
                                                       {wr, wr_word, io_we, push} : 4'h0;
      pc_load_out <= (cyc == cabx_pkg::CYC_ONE);
    end else if (busy_out && cnt_reg == 2'h1) begin
      {wr_en_out, wr_word_out, io_we_out, push_out} <=
        {pend_wr_reg, pend_word_reg, pend_io_reg, pend_push_reg};
      pc_load_out <= 1'b1;
    end else begin
      {wr_en_out, wr_word_out, io_we_out, push_out, pc_load_out} <= 5'h00;
    end
  end

  // ****************
  // data held from issue
  // ****************
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      result_out    <= 8'h00;
      result_hi_out <= 8'h00;
      pc_out        <= '0;
      ret_addr_out  <= '0;
      io_addr_out   <= 6'h00;
      io_wdata_out  <= 8'h00;
    end else if (take) begin
      result_out    <= res_lo;
      result_hi_out <= res_hi;
      pc_out        <= npc;
      ret_addr_out  <= pc_seq;
      io_addr_out   <= io_addr_in;
      io_wdata_out  <= io_wdata;
    end
  end

  // ****************
  // checks
  // ****************
  sequence s_two;
    busy_out ##1 done_out;
  endsequence
  sequence s_three;
    busy_out [*2] ##1 done_out;
  endsequence

  property p_add_one;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      take && op_in == cabx_pkg::op_add |=> done_out && wr_en_out;
  endproperty
  a_add_one: assert property (p_add_one) else $error("add not done in one cycle");

  property p_word_two;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      take && op_in == cabx_pkg::op_subtract_immediate_word |=> s_two ##0 wr_word_out;
  endproperty
  a_word_two: assert property (p_word_two) else $error("word op not two cycles");

  property p_logic_keeps_c;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      take && op_in == cabx_pkg::op_exclusive_or |=>
        status_flags_out[cabx_pkg::FLAG_C] == $past(status_flags_out[cabx_pkg::FLAG_C]) &&
        !status_flags_out[cabx_pkg::FLAG_V];
  endproperty
  a_logic_keeps_c: assert property (p_logic_keeps_c) else $error("logic op touched carry");

  property p_mask_clear;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      take && op_in == cabx_pkg::op_clear_bits_by_mask |=>
        (result_out & $past(imm_in)) == 8'h00;
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("mask bits not cleared");

  property p_call_three;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      take && op_in == cabx_pkg::op_pointer_subroutine |=> s_three ##0 push_out && pc_load_out;
  endproperty
  a_call_three: assert property (p_call_three) else $error("call not three cycles");

  property p_skip_two_word;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      take && op_in == cabx_pkg::op_compare_skip_equal && rd_val_in == rr_val_in &&
      next_two_word_in |=> s_three ##0 pc_out == $past(pc_in, 3) + PC_W'(3);
  endproperty
  a_skip_two_word: assert property (p_skip_two_word) else $error("skip of long word wrong");

  property p_ge_not_taken;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      take && op_in == cabx_pkg::op_branch_signed_ge &&
      (status_flags_out[cabx_pkg::FLAG_N] ^ status_flags_out[cabx_pkg::FLAG_V]) |=>
        done_out && pc_out == $past(pc_in) + PC_W'(1);
  endproperty
  a_ge_not_taken: assert property (p_ge_not_taken) else $error("ge branch taken wrongly");

  property p_io_refused;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      take && (op_in == cabx_pkg::op_set_io_bit || op_in == cabx_pkg::op_clear_io_bit) &&
      io_addr_in > cabx_pkg::IO_BIT_ADDR_MAX |=>
        !io_we_out ##1 done_out && !io_we_out;
  endproperty
  a_io_refused: assert property (p_io_refused) else $error("io bit write above range");

  property p_rol_carry;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      take && op_in == cabx_pkg::op_rotate_left_carry |=>
        status_flags_out[cabx_pkg::FLAG_C] == $past(rd_val_in[7]) &&
        result_out[0] == $past(status_flags_out[cabx_pkg::FLAG_C]);
  endproperty
  a_rol_carry: assert property (p_rol_carry) else $error("rotate carry path wrong");
endmodule

// [verification/tb.sv]
// bench for the execute block: one task per scenario
// assumes 40 MHz core clock, inputs driven on falling edge
`timescale 1ns/1ps
module tb;
  logic core_clk_in, sys_rst_in, start_in, next_two_word_in, status_load_in;
  cabx_pkg::cabx_op_t op_in;
  logic [7:0] rd_val_in, rdh_val_in, rr_val_in, imm_in, io_rdata_in, status_wdata_in;
  logic [2:0] bit_sel_in;
  logic [6:0] offset_in;
  logic [15:0] pc_in, z_ptr_in, pc_out, ret_addr_out;
  logic [5:0] io_addr_in, io_addr_out;
  logic busy_out, done_out, wr_en_out, wr_word_out, pc_load_out, push_out, io_we_out;
  logic [7:0] status_flags_out, result_out, result_hi_out, io_wdata_out;
  int bad_count, checked, ticks;
  cabx_execute DUT (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in), .op_in(op_in),
    .rd_val_in(rd_val_in), .rdh_val_in(rdh_val_in), .rr_val_in(rr_val_in), .imm_in(imm_in),
    .bit_sel_in(bit_sel_in), .offset_in(offset_in), .pc_in(pc_in), .z_ptr_in(z_ptr_in),
    .next_two_word_in(next_two_word_in), .io_addr_in(io_addr_in), .io_rdata_in(io_rdata_in),
    .status_load_in(status_load_in), .status_wdata_in(status_wdata_in), .busy_out(busy_out),
    .done_out(done_out), .status_flags_out(status_flags_out), .wr_en_out(wr_en_out),
    .wr_word_out(wr_word_out), .result_out(result_out), .result_hi_out(result_hi_out),
    .pc_load_out(pc_load_out), .pc_out(pc_out), .push_out(push_out), .ret_addr_out(ret_addr_out),
    .io_we_out(io_we_out), .io_addr_out(io_addr_out), .io_wdata_out(io_wdata_out));
  // ****************
  // clock, timeout, helpers
  // ****************
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    ticks++;
    if (ticks == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  // issue one op, count cycles to done, check next pc
  task automatic issue(input cabx_pkg::cabx_op_t op, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] k, input int cyc, input logic [15:0] epc);
    int n;
    op_in = op; rd_val_in = a; rr_val_in = b; imm_in = k; start_in = 1'b1;
    @(negedge core_clk_in);
    start_in = 1'b0;
    n = 1;
    while (done_out !== 1'b1 && n < 6) begin
      @(negedge core_clk_in);
      n++;
    end
    chk(16'(n), 16'(cyc));
    chk(pc_out, epc);
    chk({pc_load_out, busy_out}, 2'h2);
  endtask
  task automatic load_status(input logic [7:0] v);
    status_load_in = 1'b1; status_wdata_in = v;
    @(negedge core_clk_in);
    status_load_in = 1'b0;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic s_arith();
    issue(cabx_pkg::op_add, 8'h7f, 8'h01, 8'h00, 1, 16'h0101);
    chk({wr_en_out, status_flags_out[5], status_flags_out[3:0], result_out}, {6'h3c, 8'h80});
    issue(cabx_pkg::op_add_carry, 8'h0f, 8'h01, 8'h00, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0], result_out}, {5'h10, 8'h10});
    rdh_val_in = 8'h00;
    issue(cabx_pkg::op_add_immediate_word, 8'hff, 8'h00, 8'h01, 2, 16'h0101);
    chk({wr_word_out, result_hi_out, result_out}, 17'h10100);
    rdh_val_in = 8'h01;
    issue(cabx_pkg::op_subtract_immediate_word, 8'h00, 8'h00, 8'h01, 2, 16'h0101);
    chk({result_hi_out, result_out, status_flags_out[3:0]}, {16'h00ff, 4'h0});
    issue(cabx_pkg::op_subtract, 8'h10, 8'h01, 8'h00, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0], result_out}, {5'h10, 8'h0f});
    issue(cabx_pkg::op_subtract_immediate, 8'h00, 8'h00, 8'h01, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0], result_out}, {5'h15, 8'hff});
    load_status(8'h01);
    issue(cabx_pkg::op_subtract_with_borrow, 8'h05, 8'h05, 8'h00, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0], result_out}, {5'h15, 8'hff});
    issue(cabx_pkg::op_subtract_immediate_with_borrow, 8'h10, 8'h00, 8'h0f, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0], result_out}, {5'h12, 8'h00});
    issue(cabx_pkg::op_compare_immediate, 8'h10, 8'h00, 8'h10, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0]}, 5'h02);
  endtask
  task automatic s_logic();
    load_status(8'h21);
    issue(cabx_pkg::op_and_immediate, 8'hff, 8'h00, 8'h80, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0], result_out}, {5'h15, 8'h80});
    issue(cabx_pkg::op_and, 8'hff, 8'h0f, 8'h00, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0], result_out}, {5'h11, 8'h0f});
    issue(cabx_pkg::op_exclusive_or, 8'hff, 8'h0f, 8'h00, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0], result_out}, {5'h15, 8'hf0});
    issue(cabx_pkg::op_or, 8'h01, 8'h80, 8'h00, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0], result_out}, {5'h15, 8'h81});
    issue(cabx_pkg::op_set_bits_by_mask, 8'h0c, 8'h00, 8'h30, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0], result_out}, {5'h11, 8'h3c});
    issue(cabx_pkg::op_clear_bits_by_mask, 8'hf0, 8'h00, 8'h30, 1, 16'h0101);
    chk(result_out, 8'hc0);
    issue(cabx_pkg::op_test_zero_minus, 8'h00, 8'h00, 8'h00, 1, 16'h0101);
    chk({status_flags_out[5], status_flags_out[3:0]}, 5'h13);
    issue(cabx_pkg::op_rotate_left_carry, 8'h80, 8'h00, 8'h00, 1, 16'h0101);
    chk({status_flags_out[3:0], result_out}, {4'h9, 8'h01});
  endtask
  task automatic s_flow();
    issue(cabx_pkg::op_pointer_subroutine, 8'h00, 8'h00, 8'h00, 3, 16'h0234);
    chk({push_out, ret_addr_out, status_flags_out[3:0]}, {1'b1, 16'h0101, 4'h9});
    issue(cabx_pkg::op_pointer_jump, 8'h00, 8'h00, 8'h00, 2, 16'h0234);
    next_two_word_in = 1'b1;
    issue(cabx_pkg::op_compare_skip_equal, 8'h33, 8'h33, 8'h00, 3, 16'h0103);
    bit_sel_in = 3'h2;
    issue(cabx_pkg::op_skip_reg_bit_set, 8'h00, 8'h04, 8'h00, 3, 16'h0103);
    next_two_word_in = 1'b0;
    issue(cabx_pkg::op_skip_reg_bit_clear, 8'h00, 8'h00, 8'h00, 2, 16'h0102);
    issue(cabx_pkg::op_compare_skip_equal, 8'h33, 8'h34, 8'h00, 1, 16'h0101);
    io_rdata_in = 8'h04;
    issue(cabx_pkg::op_skip_io_bit_clear, 8'h00, 8'h00, 8'h00, 1, 16'h0101);
    issue(cabx_pkg::op_skip_io_bit_set, 8'h00, 8'h00, 8'h00, 2, 16'h0102);
  endtask
  task automatic s_branch();
    load_status(8'h24);
    offset_in = 7'h05;
    issue(cabx_pkg::op_branch_signed_lt, 8'h00, 8'h00, 8'h00, 2, 16'h0106);
    issue(cabx_pkg::op_branch_signed_ge, 8'h00, 8'h00, 8'h00, 1, 16'h0101);
    issue(cabx_pkg::op_branch_half_carry_set, 8'h00, 8'h00, 8'h00, 2, 16'h0106);
    issue(cabx_pkg::op_branch_half_carry_clear, 8'h00, 8'h00, 8'h00, 1, 16'h0101);
    issue(cabx_pkg::op_branch_irq_enabled, 8'h00, 8'h00, 8'h00, 1, 16'h0101);
    bit_sel_in = 3'h2;
    offset_in = 7'h7e;
    issue(cabx_pkg::op_branch_status_bit_set, 8'h00, 8'h00, 8'h00, 2, 16'h00ff);
    issue(cabx_pkg::op_branch_status_bit_clear, 8'h00, 8'h00, 8'h00, 1, 16'h0101);
    issue(cabx_pkg::op_branch_irq_disabled, 8'h00, 8'h00, 8'h00, 2, 16'h00ff);
    chk(status_flags_out, 8'h24);
  endtask
  task automatic s_io();
    io_addr_in = 6'h1f; io_rdata_in = 8'h00; bit_sel_in = 3'h3;
    issue(cabx_pkg::op_set_io_bit, 8'h00, 8'h00, 8'h00, 2, 16'h0101);
    chk({io_we_out, io_addr_out, io_wdata_out, status_flags_out}, {1'b1, 6'h1f, 16'h0824});
    io_addr_in = 6'h20; io_rdata_in = 8'hff;
    issue(cabx_pkg::op_clear_io_bit, 8'h00, 8'h00, 8'h00, 2, 16'h0101);
    chk(io_we_out, 1'b0);
  endtask
  initial begin
    sys_rst_in = 1'b1; start_in = 1'b0; op_in = cabx_pkg::op_none; rd_val_in = 8'h00; rdh_val_in = 8'h00;
    rr_val_in = 8'h00; imm_in = 8'h00; bit_sel_in = 3'h0; offset_in = 7'h00; pc_in = 16'h0100;
    z_ptr_in = 16'h0234; next_two_word_in = 1'b0; io_addr_in = 6'h00; io_rdata_in = 8'h00;
    status_load_in = 1'b0; status_wdata_in = 8'h00; bad_count = 0; checked = 0; ticks = 0;
    repeat (5) @(negedge core_clk_in);
    sys_rst_in = 1'b0;
    s_arith();
    s_logic();
    s_flow();
    s_branch();
    s_io();
    stop_test();
  end
endmodule
